// file: logic/clfb_seq.sv
// Bus sequencer for reads, line fills and bursts
//
// Summary of operation
// - Fill needs cache enable one clock before ready
// - Qualified fill fetches whole line regardless later
// - Line stored only if enable in final cycle
// - Enable ignored for writes and I/O cycles
// - Locked, I/O, interrupt acknowledge never fill
// - Page cache disable bits must be zero
// - No fills while cache disable bit set
// - Page cache disable output high when disabled
// - Device drives address and enables after first
// - Burst last inactive second clock, until final
// - Enable not sampled: single cycle only
// - Address strobe only with first burst address
// - Enable sampled every clock, burst last follows
// - Data latched only on ready or burst ready
// - Fixed address order set by first address
// - Narrow transfers finish word before next word
// - Ready interrupts burst, new strobe follows
// - Continuation needs no cache enable again
// - Mixed terminations keep original address order
// - Burst last active in final transfer
// - Burst stays within aligned sixteen byte line
`timescale 1ns/1ps
`include "clfb_map.svh"

module clfb_seq
(
  input  wire logic              mclk,               // Processor clock
  input  wire logic              rst,                // Async reset, active high
  input  wire logic              req_valid,          // Internal request strobe
  input  clfb_pkg::clfb_req_t    req,                // Internal request
  output logic                   req_ready,          // Sequencer idle
  input  wire logic              cache_disable_bit,  // Cache disable control bit
  input  wire logic              cache_enable_in_n,  // Cache enable pin
  input  wire logic              ready_in_n,         // Non-burst ready pin
  input  wire logic              burst_ready_in_n,   // Burst ready pin
  input  wire logic              bus_size_8_in_n,    // 8-bit bus pin
  input  wire logic              bus_size_16_in_n,   // 16-bit bus pin
  input  wire logic [31:0]       data_in,            // Data pins
  output logic                   address_strobe_out_n, // Address strobe
  output logic                   burst_last_out_n,   // Burst last
  output logic [31:0]            addr_out,           // Address bus
  output logic [3:0]             byte_en_n,          // Byte enables
  output logic                   write_out,          // Write/read select
  output logic                   page_cache_disable, // Page cache disable pin
  output logic [31:0]            rd_data,            // Latched read data
  output logic                   rd_valid,           // Data latched pulse
  output logic                   line_done,          // Transfer complete pulse
  output logic                   line_store          // Store line into cache
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [31:0] din1_r;
  logic [31:0] din2_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= 5'h1f;
      sync2_r <= 5'h1f;
      din1_r  <= 32'h0;
      din2_r  <= 32'h0;
    end
    else
    begin
      sync1_r <= {cache_enable_in_n, ready_in_n, burst_ready_in_n, bus_size_8_in_n, bus_size_16_in_n};
      sync2_r <= sync1_r;
      din1_r  <= data_in;
      din2_r  <= din1_r;
    end
  end

  logic cache_enable_in;
  logic rdy;
  logic burst_ready_in;
  logic bs8;
  logic bus_size_16_in;
  assign cache_enable_in  = ~sync2_r[4];
  assign rdy  = ~sync2_r[3];
  assign burst_ready_in = ~sync2_r[2] & ~rdy;
  assign bs8  = ~sync2_r[1];
  assign bus_size_16_in = ~sync2_r[0] & ~bs8;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  clfb_pkg::clfb_st_t s_r;
  clfb_pkg::clfb_st_t s_nxt;

  logic       done_any;
  logic [1:0] word_idx;
  logic [1:0] sub_last;
  logic       word_end;
  logic       last_xfer;
  logic       elig;

  // Burst order is first word XOR count: 0,4,8,C / 4,0,C,8 / ...
  assign word_idx = s_r.first_w ^ s_r.word_cnt[1:0];
  assign sub_last = s_r.bs8_q ? 2'h3 : (s_r.bus_size_16_in_q ? 2'h1 : 2'h0);
  assign word_end = (s_r.sub_cnt == sub_last);
  assign done_any = rdy | burst_ready_in;
  assign last_xfer = word_end && (!s_r.fill ? 1'b1 : (s_r.word_cnt == 3'h3));

  always_comb
  begin
    elig = (req.kind == clfb_pkg::CY_MEM_READ) && !req.locked
           && !cache_disable_bit
           && (req.paging ? (req.is_dir ? !req.pcd_dir : !req.pcd_pte)
                          : !req.cr3_pcd);
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.address_strobe_out = 1'b0;
    s_nxt.data_vld = 1'b0;
    s_nxt.line_done = 1'b0;
    s_nxt.line_store = 1'b0;
    s_nxt.ken_q = cache_enable_in;
    s_nxt.pcd_out = cache_disable_bit;
    s_nxt.first_clk = 1'b0;
    case (s_r.state)
      clfb_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          s_nxt.state = clfb_pkg::ST_DATA;
          s_nxt.base = req.addr;
          s_nxt.first_w = req.addr[3:2];
          s_nxt.word_cnt = 3'h0;
          s_nxt.sub_cnt = 2'h0;
          s_nxt.fill = 1'b0;
          s_nxt.eligible = elig;
          s_nxt.kind_write = (req.kind == clfb_pkg::CY_WRITE);
          s_nxt.address_strobe_out = 1'b1;
          s_nxt.first_clk = 1'b1;
          s_nxt.burst_last_out = !req.multi;
        end
      end
      clfb_pkg::ST_DATA:
      begin
        // Decision tracks the pins until the first data cycle ends, so the
        // enable seen in the clock before ready is the one that counts
        if (s_r.word_cnt == 3'h0 && s_r.sub_cnt == 2'h0 && (s_r.first_clk || !done_any))
        begin
          s_nxt.fill = s_r.eligible && !s_r.kind_write && cache_enable_in;
          s_nxt.bs8_q = bs8;
          s_nxt.bus_size_16_in_q = bus_size_16_in;
          // Burst_last_out follows the enable by one clock; narrow words need more pieces
          s_nxt.burst_last_out = !(s_r.eligible && cache_enable_in) && !bs8 && !bus_size_16_in;
        end
        if (done_any && !s_r.first_clk)
        begin
          s_nxt.data = din2_r;
          s_nxt.data_vld = !s_r.kind_write;
          if (last_xfer)
          begin
            s_nxt.state = clfb_pkg::ST_IDLE;
            s_nxt.line_done = 1'b1;
            s_nxt.line_store = s_r.fill && s_r.ken_q;
            s_nxt.burst_last_out = 1'b1;
          end
          else
          begin
            if (word_end)
            begin
              s_nxt.word_cnt = s_r.word_cnt + 3'h1;
              s_nxt.sub_cnt = 2'h0;
            end
            else
            begin
              s_nxt.sub_cnt = s_r.sub_cnt + 2'h1;
            end
            // Final transfer next: raise burst_last_out before it
            s_nxt.burst_last_out = s_r.fill ? (word_end ? (s_r.word_cnt == 3'h2) && (sub_last == 2'h0)
                                               : (s_r.word_cnt == 3'h3) && (s_r.sub_cnt + 2'h1 == sub_last))
                                   : (s_r.sub_cnt + 2'h1 == sub_last);
            if (rdy)
            begin
              s_nxt.address_strobe_out = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_nxt.state = clfb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.state <= clfb_pkg::ST_IDLE;
      s_r.burst_last_out <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [1:0] byte_sel;
  assign byte_sel = s_r.bs8_q ? s_r.sub_cnt : (s_r.bus_size_16_in_q ? {s_r.sub_cnt[0], 1'b0} : 2'h0);

  assign req_ready = (s_r.state == clfb_pkg::ST_IDLE);
  assign address_strobe_out_n = ~s_r.address_strobe_out;
  assign burst_last_out_n = ~s_r.burst_last_out;
  assign write_out = s_r.kind_write;
  assign page_cache_disable = s_r.pcd_out;
  assign rd_data = s_r.data;
  assign rd_valid = s_r.data_vld;
  assign line_done = s_r.line_done;
  assign line_store = s_r.line_store;

  always_comb
  begin
    // Upper line bits stay fixed for the whole burst
    addr_out = {s_r.base[31:4], word_idx, byte_sel};
    // Narrow pieces enable only the bytes still owed in the word
    byte_en_n = (s_r.word_cnt == 3'h0 && s_r.sub_cnt == 2'h0) ? `CLFB_ALL_BE : ~(4'hf << byte_sel);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_line_base_stable: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && $past(s_r.state) == clfb_pkg::ST_DATA)
    |-> addr_out[31:4] == $past(addr_out[31:4]))
    else $error("line base moved in burst");
  a_order_xor: assert property (@(posedge mclk) disable iff (rst)
    s_r.state == clfb_pkg::ST_DATA |-> addr_out[3:2] == (s_r.first_w ^ s_r.word_cnt[1:0]))
    else $error("burst order broken");
  a_no_fill_inel: assert property (@(posedge mclk) disable iff (rst)
    (s_r.first_clk && !s_r.eligible) |=> !s_r.fill)
    else $error("ineligible cycle filled");
  a_store_needs_fill: assert property (@(posedge mclk) disable iff (rst)
    line_store |-> $past(s_r.fill) && $past(s_r.ken_q))
    else $error("store without fill");
  a_pcd_follow: assert property (@(posedge mclk) disable iff (rst)
    cache_disable_bit |=> page_cache_disable)
    else $error("pcd not driven");
  a_fill_burst_last_out_low: assert property (@(posedge mclk) disable iff (rst)
    (s_r.first_clk && s_r.eligible && !s_r.kind_write && cache_enable_in) |=> !s_r.burst_last_out)
    else $error("burst_last_out high on fill");
  a_cd_no_fill: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && cache_disable_bit) |=> !s_r.eligible)
    else $error("fill with cache disabled");
  a_done_last: assert property (@(posedge mclk) disable iff (rst)
    line_done |-> $past(s_r.burst_last_out))
    else $error("done without burst_last_out");

  // Once the first word is in, the fill must run to the end
  a_fill_holds: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && s_r.fill && (s_r.word_cnt != 3'h0 || s_r.sub_cnt != 2'h0)) |=> s_r.fill)
    else $error("fill dropped mid line");
  a_write_no_fill: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && s_r.kind_write) |-> !s_r.fill)
    else $error("write turned into fill");
  a_pte_pcd_block: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && req.paging && !req.is_dir && req.pcd_pte) |=> !s_r.eligible)
    else $error("cacheable despite page disable");
  a_burst_one_strobe: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && !s_r.first_clk && burst_ready_in) |=> !s_r.address_strobe_out)
    else $error("strobe inside burst");
  a_ready_restrobe: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && !s_r.first_clk && rdy && !last_xfer) |=> s_r.address_strobe_out)
    else $error("no new strobe after ready");
  a_data_on_ready: assert property (@(posedge mclk) disable iff (rst)
    rd_valid |-> $past(done_any))
    else $error("data latched without ready");
  a_single_one_word: assert property (@(posedge mclk) disable iff (rst)
    (line_done && !s_r.fill) |-> s_r.word_cnt == 3'h0)
    else $error("extra words without fill");
  a_burst_last_out_follows: assert property (@(posedge mclk) disable iff (rst)
    (s_r.state == clfb_pkg::ST_DATA && s_r.word_cnt == 3'h0 && s_r.sub_cnt == 2'h0 && !done_any
     && s_r.eligible && cache_enable_in) |=> !s_r.burst_last_out)
    else $error("burst_last_out not following enable");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  c_fill_store: cover property (@(posedge mclk) disable iff (rst) line_store);
  c_interrupt: cover property (@(posedge mclk) disable iff (rst) rdy && s_r.fill && !last_xfer);
  c_narrow: cover property (@(posedge mclk) disable iff (rst) s_r.bs8_q && rd_valid);
  c_single: cover property (@(posedge mclk) disable iff (rst) line_done && !s_r.fill);
  c_wait_state: cover property (@(posedge mclk) disable iff (rst) s_r.fill && s_r.word_cnt != 3'h0 && !done_any);

endmodule

// file: logic/clfb_map.svh
// Constants for the cache line fill burst bus sequencer
`ifndef CLFB_MAP_SVH
`define CLFB_MAP_SVH
`define CLFB_LINE_WORDS   3'h4
`define CLFB_WORD_BYTES   4'h4
`define CLFB_ALL_BE       4'h0
`define CLFB_LINE_MASK    32'hffff_fff0
`endif

// file: logic/clfb_pkg.sv
// Types for the cache line fill burst bus sequencer
package clfb_pkg;
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_ADDR  = 4'h2,
    ST_DATA  = 4'h4,
    ST_DONE  = 4'h8
  } clfb_state_t;

  typedef enum logic [1:0]
  {
    CY_MEM_READ = 2'h0,
    CY_IO_READ  = 2'h1,
    CY_INTA     = 2'h2,
    CY_WRITE    = 2'h3
  } clfb_kind_t;

  typedef struct packed
  {
    logic [31:0] addr;
    clfb_kind_t  kind;
    logic        locked;
    logic        code;
    logic        pcd_pte;
    logic        pcd_dir;
    logic        paging;
    logic        is_dir;
    logic        cr3_pcd;
    logic        multi;
  } clfb_req_t;

  typedef struct packed
  {
    clfb_state_t state;
    logic [31:0] base;
    logic [1:0]  first_w;
    logic [2:0]  word_cnt;
    logic [1:0]  sub_cnt;
    logic        fill;
    logic        eligible;
    logic        burst_last_out;
    logic        address_strobe_out;
    logic        ken_q;
    logic        bs8_q;
    logic        bus_size_16_in_q;
    logic        first_clk;
    logic        kind_write;
    logic [31:0] data;
    logic        data_vld;
    logic        line_done;
    logic        line_store;
    logic        pcd_out;
  } clfb_st_t;
endpackage

// file: sim/clfb_mem.sv
// External memory model answering the bus sequencer
`timescale 1ns/1ps
module clfb_mem
(
  input  wire logic        mclk,              // Clock
  input  wire logic        rst,               // Reset
  input  wire logic        strobe_n,          // Cycle start
  input  wire logic        last_n,            // Final transfer mark
  input  wire logic [31:0] addr,              // Address bus
  input  wire logic        fill_on,           // Offer a line fill
  input  wire logic        store_on,          // Allow store at the end
  input  wire logic        burst_on,          // Answer with burst ready
  input  wire logic [4:0]  cut,               // Transfer answered by plain ready
  input  wire logic [2:0]  waits,             // Extra wait states
  input  wire logic        w8,                // Byte wide memory
  input  wire logic        w16,               // Half wide memory
  output logic             cache_enable_in_n, // Cache enable pin
  output logic             ready_in_n,        // Ready pin
  output logic             burst_ready_in_n,  // Burst ready pin
  output logic             bus_size_8_in_n,   // Byte bus pin
  output logic             bus_size_16_in_n,  // Half bus pin
  output logic [31:0]      data_in            // Data pins
);
  logic [4:0] n;
  logic       fin;
  assign bus_size_8_in_n  = ~w8;
  assign bus_size_16_in_n = ~w16;
  initial
  begin
    ready_in_n = 1'b1;
    burst_ready_in_n = 1'b1;
    cache_enable_in_n = 1'b1;
    data_in = 32'h0;
  end
  // --------------------------------------------
  // One whole cycle per strobe seen while idle, answered until burst last
  // --------------------------------------------
  always
  begin
    @(negedge mclk);
    cache_enable_in_n = ~fill_on;
    if (!rst && !strobe_n)
    begin
      n = 5'h0;
      fin = 1'b0;
      while (!fin)
      begin
        // Inputs pass a synchroniser, so answers are spaced out
        repeat (4) @(negedge mclk);
        fin = !last_n;
        if (n != 5'h0)
          cache_enable_in_n = fin ? ~store_on : 1'b1;
        repeat (waits + 2) @(negedge mclk);
        data_in = {8'hd0, addr[23:0]};
        if (burst_on && n != cut)
          burst_ready_in_n = 1'b0;
        else
          ready_in_n = 1'b0;
        @(negedge mclk);
        ready_in_n = 1'b1;
        burst_ready_in_n = 1'b1;
        data_in = ~data_in; // Released bus never repeats the word
        n = n + 5'h1;
      end
    end
  end
endmodule

// file: sim/clfb_seq_tb.sv
// Self-checking bench for the bus sequencer
`timescale 1ns/1ps
module clfb_seq_tb;
  localparam clfb_pkg::clfb_req_t base_req = '{kind: clfb_pkg::CY_MEM_READ, paging: 1'b1, default: '0};
  logic                mclk, rst, req_valid, req_ready, cache_disable_bit, page_cache_disable;
  logic                cen_n, ack_n, back_n, n8_n, n16_n, strobe_n, last_n, rd_valid, line_done, line_store;
  logic [31:0]         data_in, addr_out, rd_data;
  clfb_pkg::clfb_req_t rq;
  logic                fill_on, store_on, burst_on, w8, w16, wr;
  logic [4:0]          cut;
  logic [2:0]          waits;
  logic [3:0]          seen[$];
  logic [31:0]         dq[$];
  int                  fails, total_checks, strobes, stores;
  clfb_seq DUT
  (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(rq), .req_ready(req_ready),
    .cache_disable_bit(cache_disable_bit), .cache_enable_in_n(cen_n), .ready_in_n(ack_n),
    .burst_ready_in_n(back_n), .bus_size_8_in_n(n8_n), .bus_size_16_in_n(n16_n), .data_in(data_in),
    .address_strobe_out_n(strobe_n), .burst_last_out_n(last_n), .addr_out(addr_out), .byte_en_n(),
    .write_out(wr), .page_cache_disable(page_cache_disable), .rd_data(rd_data), .rd_valid(rd_valid),
    .line_done(line_done), .line_store(line_store)
  );
  clfb_mem mem
  (
    .mclk(mclk), .rst(rst), .strobe_n(strobe_n), .last_n(last_n), .addr(addr_out), .fill_on(fill_on),
    .store_on(store_on), .burst_on(burst_on), .cut(cut), .waits(waits), .w8(w8), .w16(w16),
    .cache_enable_in_n(cen_n), .ready_in_n(ack_n), .burst_ready_in_n(back_n), .bus_size_8_in_n(n8_n),
    .bus_size_16_in_n(n16_n), .data_in(data_in)
  );
  always #10 mclk = ~mclk;
  // --------------------------------------------
  // Checking and bus watching
  // --------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task stop_test;
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    if (!rst && (!ack_n || !back_n))
    begin
      seen.push_back(addr_out[3:0]);
      dq.push_back(data_in);
      chk("line_area", 32'(rq.addr[31:4]), 32'(addr_out[31:4]));
    end
    if (!rst && !strobe_n)
      strobes++;
    if (!rst && line_store)
      stores++;
    if (!rst && rd_valid && !w8 && !w16 && dq.size() > 0)
      chk("rd_data", dq.pop_front(), rd_data);
  end
  // Expected order is worked out per word, then per narrow piece
  task automatic run(input logic [31:0] a, input int words, input int address_strobe_out, input logic st);
    int per;
    int i;
    per = w8 ? 4 : (w16 ? 2 : 1);
    seen.delete();
    dq.delete();
    strobes = 0;
    stores = 0;
    rq.addr = a;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    i = 0;
    while (line_done !== 1'b1 && i < 500)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    chk("finished", 1, i < 500);
    repeat (6) @(negedge mclk);
    chk("transfers", words * per, seen.size());
    for (i = 0; i < seen.size(); i++)
      chk("order", 32'({a[3:2] ^ 2'(i / per), 2'b00} + (w8 ? i % per : 2 * (i % per))), seen[i]);
    chk("strobes", address_strobe_out, strobes);
    chk("store", st, stores);
    chk("write_sel", 32'(rq.kind == clfb_pkg::CY_WRITE), 32'(wr));
  endtask
  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task t_orders;
    for (int k = 0; k < 4; k++)
      run(32'h0000_1000 + 32'(4 * k), 4, 1, 1'b1);
  endtask
  task t_single;
    fill_on = 1'b0;
    run(32'h0000_1008, 1, 1, 1'b0);
    fill_on = 1'b1;
  endtask
  task t_nostore;
    store_on = 1'b0;
    run(32'h0000_100c, 4, 1, 1'b0);
    store_on = 1'b1;
  endtask
  task t_split;
    cut = 5'h0;
    run(32'h0000_0104, 4, 2, 1'b1);
    cut = 5'h1f;
  endtask
  task t_plain;
    burst_on = 1'b0;
    waits = 3'h2;
    run(32'h0000_0108, 4, 4, 1'b1);
    burst_on = 1'b1;
    waits = 3'h0;
  endtask
  task t_refuse;
    for (int k = 0; k < 8; k++)
    begin
      rq = base_req;
      rq.paging = (k != 5);
      case (k)
        0: rq.kind = clfb_pkg::CY_IO_READ;
        1: rq.kind = clfb_pkg::CY_INTA;
        2: rq.kind = clfb_pkg::CY_WRITE;
        3: rq.locked = 1'b1;
        4: rq.pcd_pte = 1'b1;
        5: rq.cr3_pcd = 1'b1;
        6:
        begin
          rq.is_dir = 1'b1;
          rq.pcd_dir = 1'b1;
        end
        default: cache_disable_bit = 1'b1;
      endcase
      run(32'h0000_2000, 1, 1, 1'b0);
      chk("pcd_pin", cache_disable_bit, page_cache_disable);
      cache_disable_bit = 1'b0;
    end
    rq = base_req;
  endtask
  task t_narrow;
    w16 = 1'b1;
    run(32'h0000_0004, 4, 1, 1'b1);
    w16 = 1'b0;
    w8 = 1'b1;
    run(32'h0000_000c, 4, 1, 1'b1);
    w8 = 1'b0;
  endtask
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    cache_disable_bit = 1'b0;
    rq = base_req;
    {fill_on, store_on, burst_on, w8, w16} = 5'h1c;
    cut = 5'h1f;
    waits = 3'h0;
    repeat (20) @(negedge mclk);
    chk("idle_ready", 1, req_ready);
    chk("idle_strobe", 1, strobe_n);
    rst = 1'b0;
    @(negedge mclk);
    t_orders;
    t_single;
    t_nostore;
    t_split;
    t_plain;
    t_refuse;
    t_narrow;
    stop_test;
  end
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
endmodule
